// ===== src/amc_consts.svh
// register offsets, field positions, reset values and codes for amc
`ifndef AMC_CONSTS_SVH
`define AMC_CONSTS_SVH

// =============================================================
// register offsets
`define AMC_ADDR_W          8
`define AMC_OFF_CTRL        8'h09
`define AMC_OFF_RSVD_A      8'h0A
`define AMC_OFF_OFS_LOW     8'h0B
`define AMC_OFF_OFS_HIGH    8'h0C
`define AMC_OFF_RSVD_D      8'h0D
`define AMC_OFF_FS_LOW      8'h0E
`define AMC_OFF_FS_HIGH     8'h0F
`define AMC_OFF_STATUS      8'h12

// =============================================================
// reset values
`define AMC_RST_CTRL        8'h10
`define AMC_RST_RSVD        8'h00
`define AMC_RST_OFS_LOW     8'h00
`define AMC_RST_OFS_HIGH    8'h00
`define AMC_RST_FS_LOW      8'h00
`define AMC_RST_FS_HIGH     8'h40

// =============================================================
// control register fields
`define AMC_MON_HI          7
`define AMC_MON_LO          5
`define AMC_AVG_HI          4
`define AMC_AVG_LO          3
`define AMC_TMO_BIT         2
`define AMC_CTRL_RSV_HI     1
`define AMC_CTRL_RSV_LO     0

// =============================================================
// status register fields
`define AMC_ST_GAIN_HIGH    0
`define AMC_ST_AMP_OFF      1
`define AMC_ST_PENDING      2

// =============================================================
// amplifier codes
`define AMC_GAIN_ONE        3'h0
`define AMC_GAIN_FOUR       3'h2
`define AMC_AMP_ON          2'h1

// =============================================================
// averaged calibration sample counts
`define AMC_AVG_N0          5'h01
`define AMC_AVG_N1          5'h04
`define AMC_AVG_N2          5'h08
`define AMC_AVG_N3          5'h10

`endif

// ===== src/amc_pkg.sv
// types shared by the amc register slice
package amc_pkg;

    // =========================================================
    // monitor selection codes, in field order
    typedef enum logic [2:0] {
        AMC_MON_OFF,
        AMC_MON_MIDPOINT,
        AMC_MON_TEMP,
        AMC_MON_ASUPPLY,
        AMC_MON_DSUPPLY,
        AMC_MON_BURN_LOW,
        AMC_MON_BURN_MID,
        AMC_MON_BURN_HIGH
    } amc_mon_e;

    typedef enum logic [1:0] {
        AMC_BURN_NONE,
        AMC_BURN_0U2,
        AMC_BURN_1U,
        AMC_BURN_10U
    } amc_burn_e;

    // =========================================================
    // steering handed to the analog front end
    typedef struct packed {
        logic      shortToMid;
        logic      tempRoute;
        logic      aSupplyRoute;
        logic      dSupplyRoute;
        logic      muxOpen;
        amc_burn_e burnLevel;
        logic [2:0] gain;
    } amc_mon_s;

    // completed calibration results
    typedef struct packed {
        logic        done;
        logic        offsetValid;
        logic        gainValid;
        logic [15:0] offset;
        logic [15:0] gain;
    } amc_cal_s;

endpackage : amc_pkg

// ===== src/amc_monitor_decode.sv
// decodes the monitor selection into front-end steering
`timescale 1ns/1ps
`default_nettype none
`include "amc_consts.svh"

module amc_monitor_decode
    import amc_pkg::*;
(
    input  wire logic [2:0] monCode,
    input  wire logic [2:0] userGain,
    output amc_mon_s        steer
);

    amc_mon_e mon;

    always_comb begin
        mon = amc_mon_e'(monCode);
        steer = '0;
        steer.gain = userGain;
        unique case (mon)
            AMC_MON_OFF: begin
            end
            AMC_MON_MIDPOINT: begin
                steer.shortToMid = 1'b1;
            end
            AMC_MON_TEMP: begin
                steer.tempRoute = 1'b1;
            end
            AMC_MON_ASUPPLY: begin
                steer.aSupplyRoute = 1'b1;
                steer.gain = `AMC_GAIN_ONE;
            end
            AMC_MON_DSUPPLY: begin
                steer.dSupplyRoute = 1'b1;
                steer.gain = `AMC_GAIN_ONE;
            end
            AMC_MON_BURN_LOW: begin
                steer.burnLevel = AMC_BURN_0U2;
            end
            AMC_MON_BURN_MID: begin
                steer.burnLevel = AMC_BURN_1U;
            end
            AMC_MON_BURN_HIGH: begin
                steer.burnLevel = AMC_BURN_10U;
            end
        endcase
        // burn-out sources sit on the inputs, so the mux stays closed
        steer.muxOpen = steer.shortToMid | steer.tempRoute
                      | steer.aSupplyRoute | steer.dSupplyRoute;
    end

endmodule : amc_monitor_decode

`default_nettype wire

// ===== src/amc_regs.sv
// monitor, calibration-average, timeout and trim register slice
//
// Our own choice: strobed register access.
`timescale 1ns/1ps
`default_nettype none
`include "amc_consts.svh"

module amc_regs
    import amc_pkg::*;
#(
    parameter int TRIM_W = 16
) (
    input  wire logic                    clk_sys,
    input  wire logic                    sys_rst,
    // register port
    input  wire logic [`AMC_ADDR_W-1:0]  regAddr,
    input  wire logic [7:0]              regWrData,
    input  wire logic                    regWrEn,
    input  wire logic                    regRdEn,
    output logic      [7:0]              regRdData,
    // amplifier settings held elsewhere
    input  wire logic [2:0]              userGain,
    input  wire logic [1:0]              amplifierEnableField,
    // calibration engine and conversion sequencer
    input  wire amc_cal_s                calResult,
    input  wire logic                    conversionStart,
    // steering and settings
    output amc_mon_s                     monitorSteer,
    output logic [4:0]                   calibrationAverageCount,
    output logic                         timeoutEnable,
    output logic [TRIM_W-1:0]            offsetTrimValue,
    output logic [TRIM_W-1:0]            fullScaleTrimValue
);

    // =========================================================
    // elaboration check
    generate
        if (TRIM_W != 16) begin : gTrimWidth
            $error("amc_regs: trim words are two bytes wide");
        end
    endgenerate

    // =========================================================
    // register state
    logic [7:0]        ctrl_reg;
    logic [7:0]        ctrl_next;
    logic [7:0]        ofsLow_reg;
    logic [7:0]        ofsLow_next;
    logic [7:0]        ofsHigh_reg;
    logic [7:0]        ofsHigh_next;
    logic [7:0]        fsLow_reg;
    logic [7:0]        fsLow_next;
    logic [7:0]        fsHigh_reg;
    logic [7:0]        fsHigh_next;

    logic              wrCtrl;
    logic              wrOfsLow;
    logic              wrOfsHigh;
    logic              wrFsLow;
    logic              wrFsHigh;
    logic              calOfs;
    logic              calFs;

    always_comb begin
        wrCtrl    = regWrEn && (regAddr == `AMC_OFF_CTRL);
        wrOfsLow  = regWrEn && (regAddr == `AMC_OFF_OFS_LOW);
        wrOfsHigh = regWrEn && (regAddr == `AMC_OFF_OFS_HIGH);
        wrFsLow   = regWrEn && (regAddr == `AMC_OFF_FS_LOW);
        wrFsHigh  = regWrEn && (regAddr == `AMC_OFF_FS_HIGH);
        calOfs    = calResult.done && calResult.offsetValid;
        calFs     = calResult.done && calResult.gainValid;
    end

    always_comb begin
        ctrl_next    = ctrl_reg;
        ofsLow_next  = ofsLow_reg;
        ofsHigh_next = ofsHigh_reg;
        fsLow_next   = fsLow_reg;
        fsHigh_next  = fsHigh_reg;
        // reserved bits 1:0 are plain storage; zero is expected there
        if (wrCtrl) begin
            ctrl_next = regWrData;
        end
        if (wrOfsLow) begin
            ofsLow_next = regWrData;
        end
        if (wrOfsHigh) begin
            ofsHigh_next = regWrData;
        end
        if (wrFsLow) begin
            fsLow_next = regWrData;
        end
        if (wrFsHigh) begin
            fsHigh_next = regWrData;
        end
        // a finishing calibration beats a same-cycle software write
        if (calOfs) begin
            ofsLow_next  = calResult.offset[7:0];
            ofsHigh_next = calResult.offset[15:8];
        end
        if (calFs) begin
            fsLow_next  = calResult.gain[7:0];
            fsHigh_next = calResult.gain[15:8];
        end
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            ctrl_reg    <= `AMC_RST_CTRL;
            ofsLow_reg  <= `AMC_RST_OFS_LOW;
            ofsHigh_reg <= `AMC_RST_OFS_HIGH;
            fsLow_reg   <= `AMC_RST_FS_LOW;
            fsHigh_reg  <= `AMC_RST_FS_HIGH;
        end else begin
            ctrl_reg    <= ctrl_next;
            ofsLow_reg  <= ofsLow_next;
            ofsHigh_reg <= ofsHigh_next;
            fsLow_reg   <= fsLow_next;
            fsHigh_reg  <= fsHigh_next;
        end
    end

    // =========================================================
    // trims in use by the converter
    // values move over only when a conversion starts, so a word
    // written byte by byte is used half old and half new only if a conversion starts between its byte writes
    logic [TRIM_W-1:0] ofsApplied_reg;
    logic [TRIM_W-1:0] ofsApplied_next;
    logic [TRIM_W-1:0] fsApplied_reg;
    logic [TRIM_W-1:0] fsApplied_next;
    logic              pending_reg;
    logic              pending_next;
    logic              trimTouched;

    always_comb begin
        trimTouched = wrOfsLow | wrOfsHigh | wrFsLow | wrFsHigh
                    | calOfs | calFs;
        ofsApplied_next = ofsApplied_reg;
        fsApplied_next  = fsApplied_reg;
        pending_next    = pending_reg;
        if (conversionStart) begin
            ofsApplied_next = {ofsHigh_reg, ofsLow_reg};
            fsApplied_next  = {fsHigh_reg, fsLow_reg};
            pending_next    = 1'b0;
        end
        // an update in the start cycle waits for the next conversion
        if (trimTouched) begin
            pending_next = 1'b1;
        end
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            ofsApplied_reg <= {`AMC_RST_OFS_HIGH, `AMC_RST_OFS_LOW};
            fsApplied_reg  <= {`AMC_RST_FS_HIGH, `AMC_RST_FS_LOW};
            pending_reg    <= 1'b0;
        end else begin
            ofsApplied_reg <= ofsApplied_next;
            fsApplied_reg  <= fsApplied_next;
            pending_reg    <= pending_next;
        end
    end

    // =========================================================
    // monitor steering
    amc_mon_s steerComb;
    amc_mon_s steer_reg;
    amc_mon_s steer_next;

    amc_monitor_decode uDecode (
        .monCode  (ctrl_reg[`AMC_MON_HI:`AMC_MON_LO]),
        .userGain (userGain),
        .steer    (steerComb)
    );

    always_comb begin
        steer_next = steerComb;
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            // monitor off after reset: user gain is not known yet
            steer_reg <= '0;
        end else begin
            steer_reg <= steer_next;
        end
    end

    // =========================================================
    // settings decoded from the control register
    logic [4:0] avgCount_reg;
    logic [4:0] avgCount_next;
    logic       timeout_reg;
    logic       timeout_next;

    always_comb begin
        unique case (ctrl_reg[`AMC_AVG_HI:`AMC_AVG_LO])
            2'h0:    avgCount_next = `AMC_AVG_N0;
            2'h1:    avgCount_next = `AMC_AVG_N1;
            2'h2:    avgCount_next = `AMC_AVG_N2;
            2'h3:    avgCount_next = `AMC_AVG_N3;
        endcase
        timeout_next = ctrl_reg[`AMC_TMO_BIT];
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            avgCount_reg <= `AMC_AVG_N2;
            timeout_reg  <= 1'b0;
        end else begin
            avgCount_reg <= avgCount_next;
            timeout_reg  <= timeout_next;
        end
    end

    // =========================================================
    // temperature measurement sanity, for software to inspect
    // the device cannot refuse a bad setting, it only reports it
    logic tempGainHigh;
    logic tempAmpOff;

    always_comb begin
        tempGainHigh = steer_reg.tempRoute
                     && (userGain > `AMC_GAIN_FOUR);
        tempAmpOff   = steer_reg.tempRoute
                     && (amplifierEnableField != `AMC_AMP_ON);
    end

    // =========================================================
    // read path: data stand in the cycle after the strobe only
    logic [7:0] rdData_reg;
    logic [7:0] rdData_next;
    logic [7:0] statusWord;

    always_comb begin
        statusWord = 8'h00;
        statusWord[`AMC_ST_GAIN_HIGH] = tempGainHigh;
        statusWord[`AMC_ST_AMP_OFF]   = tempAmpOff;
        statusWord[`AMC_ST_PENDING]   = pending_reg;
        rdData_next = 8'h00;
        if (regRdEn) begin
            unique case (regAddr)
                `AMC_OFF_CTRL:     rdData_next = ctrl_reg;
                `AMC_OFF_RSVD_A:   rdData_next = `AMC_RST_RSVD;
                `AMC_OFF_OFS_LOW:  rdData_next = ofsLow_reg;
                `AMC_OFF_OFS_HIGH: rdData_next = ofsHigh_reg;
                `AMC_OFF_RSVD_D:   rdData_next = `AMC_RST_RSVD;
                `AMC_OFF_FS_LOW:   rdData_next = fsLow_reg;
                `AMC_OFF_FS_HIGH:  rdData_next = fsHigh_reg;
                `AMC_OFF_STATUS:   rdData_next = statusWord;
                default:           rdData_next = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            rdData_reg <= 8'h00;
        end else begin
            rdData_reg <= rdData_next;
        end
    end

    // reserved locations have no write decode at all

    // =========================================================
    // outputs
    always_comb begin
        regRdData               = rdData_reg;
        monitorSteer            = steer_reg;
        calibrationAverageCount = avgCount_reg;
        timeoutEnable           = timeout_reg;
        offsetTrimValue         = ofsApplied_reg;
        fullScaleTrimValue      = fsApplied_reg;
    end

endmodule : amc_regs

`default_nettype wire

// ===== tb/amc_regs_checker.sv
// concurrent checks on the ports of the amc register slice
`timescale 1ns/1ps
`default_nettype none
`include "amc_consts.svh"

module amc_regs_checker
    import amc_pkg::*;
#(
    parameter int TRIM_W = 16
) (
    input wire logic              clk_sys,
    input wire logic              sys_rst,
    input wire logic [7:0]        regAddr,
    input wire logic [7:0]        regWrData,
    input wire logic              regWrEn,
    input wire logic              regRdEn,
    input wire logic [7:0]        regRdData,
    input wire logic [2:0]        userGain,
    input wire logic [1:0]        amplifierEnableField,
    input wire amc_cal_s          calResult,
    input wire logic              conversionStart,
    input wire amc_mon_s          monitorSteer,
    input wire logic [4:0]        calibrationAverageCount,
    input wire logic              timeoutEnable,
    input wire logic [TRIM_W-1:0] offsetTrimValue,
    input wire logic [TRIM_W-1:0] fullScaleTrimValue
);
    // =========================================================
    // register port
    default clocking @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    rd_slot_only_a: assert property (
        regRdData != 8'h00 |-> $past(regRdEn))
        else $error("read data outside its slot");
    rsvd_read_zero_a: assert property (
        $past(regRdEn) && ($past(regAddr) == `AMC_OFF_RSVD_A
        || $past(regAddr) == `AMC_OFF_RSVD_D) |-> regRdData == 8'h00)
        else $error("reserved location read nonzero");
    reset_values_a: assert property (
        $fell(sys_rst) |-> calibrationAverageCount == 5'h08
        && !timeoutEnable && fullScaleTrimValue == 16'h4000)
        else $error("outputs wrong after reset");
    // =========================================================
    // control fields two cycles after a write
    tmo_follow_a: assert property (
        regWrEn && regAddr == `AMC_OFF_CTRL
        |-> ##2 timeoutEnable == $past(regWrData[2], 2))
        else $error("timeout enable not following write");
    avg_follow_a: assert property (
        regWrEn && regAddr == `AMC_OFF_CTRL |-> ##2
        calibrationAverageCount == (5'h01 << ($past(regWrData[4:3], 2)
        == 2'h0 ? 3'h0 : {1'b0, $past(regWrData[4:3], 2)} + 3'h1)))
        else $error("average count wrong");
    mon_decode_a: assert property (
        regWrEn && regAddr == `AMC_OFF_CTRL |-> ##2
        monitorSteer.burnLevel == ($past(regWrData[7], 2) ?
        $past(regWrData[6:5], 2) : 2'h0) && monitorSteer.tempRoute
        == ($past(regWrData[7:5], 2) == 3'h2) && monitorSteer.shortToMid
        == ($past(regWrData[7:5], 2) == 3'h1))
        else $error("monitor decode wrong");
    // =========================================================
    // steering relations
    mux_open_a: assert property (
        regWrEn && regAddr == `AMC_OFF_CTRL |-> ##2
        monitorSteer.muxOpen == ($past(regWrData[7:5], 2) != 3'h0
        && $past(regWrData[7:5], 2) < 3'h5))
        else $error("mux open not matching monitor");
    supply_gain_a: assert property (
        monitorSteer.aSupplyRoute || monitorSteer.dSupplyRoute
        |-> monitorSteer.gain == 3'h0)
        else $error("supply monitor gain not one");
    user_gain_a: assert property (
        monitorSteer.tempRoute && $stable(userGain)
        |-> monitorSteer.gain == userGain)
        else $error("user gain not kept");
    trim_hold_a: assert property (
        !$past(conversionStart) |-> $stable(offsetTrimValue)
        && $stable(fullScaleTrimValue))
        else $error("trim moved without conversion");
endmodule // amc_regs_checker

bind amc_regs amc_regs_checker #(.TRIM_W(TRIM_W)) u_chk (
    .clk_sys, .sys_rst, .regAddr, .regWrData, .regWrEn, .regRdEn,
    .regRdData, .userGain, .amplifierEnableField, .calResult,
    .conversionStart, .monitorSteer, .calibrationAverageCount,
    .timeoutEnable, .offsetTrimValue, .fullScaleTrimValue);
`default_nettype wire

// ===== tb/amc_host_model.sv
// host model: register port master and amplifier settings
`timescale 1ns/1ps
`default_nettype none
`include "amc_consts.svh"

module amc_host_model (
    input  wire logic       clk_sys,
    input  wire logic [7:0] regRdData,
    output logic      [7:0] regAddr,
    output logic      [7:0] regWrData,
    output logic            regWrEn,
    output logic            regRdEn,
    output logic      [2:0] userGain,
    output logic      [1:0] amplifierEnableField
);
    initial begin
        regAddr = 8'h00;
        regWrData = 8'h00;
        regWrEn = 1'b0;
        regRdEn = 1'b0;
        // temperature needs the amplifier on and gain of four at most
        userGain = `AMC_GAIN_FOUR;
        amplifierEnableField = `AMC_AMP_ON;
    end

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        regAddr <= a;
        regWrData <= (a == `AMC_OFF_CTRL) ? {d[7:2], 2'h0} : d;
        regWrEn <= 1'b1;
        @(posedge clk_sys);
        regWrEn <= 1'b0;
        // released data must not keep the last value
        regWrData <= ~d;
    endtask

    task automatic set_amp(input logic [2:0] g, input logic [1:0] e);
        @(posedge clk_sys);
        userGain <= g;
        amplifierEnableField <= e;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_sys);
        regAddr <= a;
        regRdEn <= 1'b1;
        @(posedge clk_sys);
        regRdEn <= 1'b0;
        #1;
        d = regRdData;
    endtask
endmodule // amc_host_model
`default_nettype wire

// ===== tb/amc_regs_tb.sv
// self-checking testbench for the amc register slice
`timescale 1ns/1ps
`default_nettype none
`include "amc_consts.svh"

module amc_regs_tb
    import amc_pkg::*;
;
    typedef struct packed {
        logic [7:0] wrVal;
        logic [3:0] route;
        logic       mux;
        logic [1:0] burn;
        logic [2:0] gain;
        logic [4:0] avg;
        logic       tmo;
    } amc_row_s;

    logic        clk_sys;
    logic        sys_rst;
    logic [7:0]  regAddr;
    logic [7:0]  regWrData;
    logic        regWrEn;
    logic        regRdEn;
    logic [7:0]  regRdData;
    logic [2:0]  userGain;
    logic [1:0]  amplifierEnableField;
    amc_cal_s    calResult;
    logic        conversionStart;
    amc_mon_s    monitorSteer;
    logic [4:0]  calibrationAverageCount;
    logic        timeoutEnable;
    logic [15:0] offsetTrimValue;
    logic [15:0] fullScaleTrimValue;
    logic [3:0]  routeSeen;
    logic [7:0]  rdVal;
    int          n_fail;
    int          checks;

    // route bits: midpoint, temperature, analog supply, digital supply
    amc_row_s rows [8] = '{
        '{8'h00, 4'h0, 1'b0, 2'h0, 3'h2, 5'h01, 1'b0},
        '{8'h2C, 4'h8, 1'b1, 2'h0, 3'h2, 5'h04, 1'b1},
        '{8'h50, 4'h4, 1'b1, 2'h0, 3'h2, 5'h08, 1'b0},
        '{8'h7C, 4'h2, 1'b1, 2'h0, 3'h0, 5'h10, 1'b1},
        '{8'h80, 4'h1, 1'b1, 2'h0, 3'h0, 5'h01, 1'b0},
        '{8'hAC, 4'h0, 1'b0, 2'h1, 3'h2, 5'h04, 1'b1},
        '{8'hD0, 4'h0, 1'b0, 2'h2, 3'h2, 5'h08, 1'b0},
        '{8'hFC, 4'h0, 1'b0, 2'h3, 3'h2, 5'h10, 1'b1}};
    logic [7:0] rstAddr [7] = '{8'h09, 8'h0A, 8'h0B, 8'h0C, 8'h0D,
                                8'h0E, 8'h0F};
    logic [7:0] rstExp  [7] = '{8'h10, 8'h00, 8'h00, 8'h00, 8'h00,
                                8'h00, 8'h40};
    logic [7:0] trimAddr [4] = '{8'h0B, 8'h0C, 8'h0E, 8'h0F};
    logic [7:0] trimVal  [4] = '{8'h34, 8'h12, 8'h78, 8'h56};
    logic [7:0] rsvAddr  [3] = '{8'h0A, 8'h0D, 8'h20};

    assign routeSeen = {monitorSteer.shortToMid, monitorSteer.tempRoute,
                        monitorSteer.aSupplyRoute, monitorSteer.dSupplyRoute};

    amc_host_model host (.clk_sys, .regRdData, .regAddr, .regWrData,
        .regWrEn, .regRdEn, .userGain, .amplifierEnableField);
    amc_regs #(.TRIM_W(16)) uut (.clk_sys, .sys_rst, .regAddr, .regWrData,
        .regWrEn, .regRdEn, .regRdData, .userGain, .amplifierEnableField,
        .calResult, .conversionStart, .monitorSteer,
        .calibrationAverageCount, .timeoutEnable, .offsetTrimValue,
        .fullScaleTrimValue);

    // =========================================================
    // helpers
    task automatic chk(input string name, input logic [15:0] exp,
                       input logic [15:0] got);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic convert;
        @(posedge clk_sys);
        conversionStart <= 1'b1;
        @(posedge clk_sys);
        conversionStart <= 1'b0;
        @(posedge clk_sys);
        #1;
    endtask

    task automatic end_of_test;
        $display("checks %0d mismatches %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end

    initial begin
        repeat (2000) @(posedge clk_sys);
        n_fail++;
        end_of_test;
    end

    // =========================================================
    // main sequence
    initial begin
        sys_rst = 1'b1;
        conversionStart = 1'b0;
        calResult = '0;
        n_fail = 0;
        checks = 0;
        repeat (20) @(posedge clk_sys);
        sys_rst <= 1'b0;
        for (int i = 0; i < 7; i++) begin
            host.rd(rstAddr[i], rdVal);
            chk("reset read", {8'h00, rstExp[i]}, {8'h00, rdVal});
        end
        chk("fs trim reset", 16'h4000, fullScaleTrimValue);
        chk("avg reset", 16'h0008, {11'h0, calibrationAverageCount});
        for (int i = 0; i < 8; i++) begin
            host.wr(`AMC_OFF_CTRL, rows[i].wrVal);
            @(posedge clk_sys);
            #1;
            chk("routes", {12'h0, rows[i].route}, {12'h0, routeSeen});
            chk("mux", {15'h0, rows[i].mux}, {15'h0, monitorSteer.muxOpen});
            chk("burn", {14'h0, rows[i].burn},
                {14'h0, monitorSteer.burnLevel});
            chk("gain", {13'h0, rows[i].gain}, {13'h0, monitorSteer.gain});
            chk("avg", {11'h0, rows[i].avg},
                {11'h0, calibrationAverageCount});
            chk("timeout", {15'h0, rows[i].tmo}, {15'h0, timeoutEnable});
            host.rd(`AMC_OFF_CTRL, rdVal);
            chk("ctrl read", {8'h00, rows[i].wrVal}, {8'h00, rdVal});
        end
        // reserved and unmapped writes must leave zero behind
        for (int i = 0; i < 3; i++) begin
            host.wr(rsvAddr[i], 8'hA5);
            host.rd(rsvAddr[i], rdVal);
            chk("reserved read", 16'h0000, {8'h00, rdVal});
        end
        for (int i = 0; i < 4; i++) begin
            host.wr(trimAddr[i], trimVal[i]);
            host.rd(trimAddr[i], rdVal);
            chk("trim read", {8'h00, trimVal[i]}, {8'h00, rdVal});
        end
        host.rd(`AMC_OFF_STATUS, rdVal);
        chk("status pending", 16'h0004, {8'h00, rdVal});
        chk("offset held", 16'h0000, offsetTrimValue);
        convert;
        chk("offset trim", 16'h1234, offsetTrimValue);
        chk("fs trim", 16'h5678, fullScaleTrimValue);
        // calibration and a software write hit the same byte together
        fork
            host.wr(`AMC_OFF_OFS_LOW, 8'h11);
            begin
                @(posedge clk_sys);
                calResult <= '{1'b1, 1'b1, 1'b1, 16'hBEEF, 16'h4321};
                @(posedge clk_sys);
                calResult <= '0;
            end
        join
        host.rd(`AMC_OFF_OFS_HIGH, rdVal);
        chk("cal offset high", 16'h00BE, {8'h00, rdVal});
        host.rd(`AMC_OFF_OFS_LOW, rdVal);
        chk("cal offset low", 16'h00EF, {8'h00, rdVal});
        convert;
        chk("cal offset", 16'hBEEF, offsetTrimValue);
        chk("cal fs", 16'h4321, fullScaleTrimValue);
        // temperature monitor with a bad amplifier setting is reported
        host.wr(`AMC_OFF_CTRL, 8'h50);
        host.set_amp(3'h3, 2'h0);
        host.rd(`AMC_OFF_STATUS, rdVal);
        chk("temp status", 16'h0003, {8'h00, rdVal});
        chk("temp gain", 16'h0003, {13'h0, monitorSteer.gain});
        host.set_amp(`AMC_GAIN_FOUR, `AMC_AMP_ON);
        host.rd(`AMC_OFF_STATUS, rdVal);
        chk("temp status ok", 16'h0000, {8'h00, rdVal});
        // second reset in mid-run
        @(posedge clk_sys);
        sys_rst <= 1'b1;
        repeat (3) @(posedge clk_sys);
        sys_rst <= 1'b0;
        host.rd(`AMC_OFF_CTRL, rdVal);
        chk("ctrl after reset", 16'h0010, {8'h00, rdVal});
        chk("offset after reset", 16'h0000, offsetTrimValue);
        end_of_test;
    end
endmodule // amc_regs_tb
`default_nettype wire
